// ==== sqg_controls.sv ====
// Global DSCP, snooping, mirroring, WRED and PTP priority control bank.
// Assumes an APB master on clk_i and a frame parser on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sqg_controls
    import sqg_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [SQG_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Frame descriptor from the parser
    input wire logic frm_valid_i,
    input wire logic frm_ipv4_i,
    input wire logic frm_ipv6_i,
    input wire logic [7:0] frm_tos_i,
    input wire logic frm_igmp_i,
    input wire logic [7:0] frm_next_hdr_i,
    input wire logic [7:0] frm_hbh_next_hdr_i,
    input wire logic frm_src_sniff_i,
    input wire logic frm_dst_sniff_i,
    input wire logic frm_ptp_event_i,
    input wire logic frm_ptp_general_i,
    input wire logic [3:0] frm_qos_prio_i,
    // Classification result
    output logic cls_valid_o,
    output logic dscp_hit_o,
    output logic [2:0] dscp_prio_o,
    output logic host_fwd_o,
    output logic mld_pkt_o,
    output logic mirror_o,
    output logic [3:0] queue_prio_o,
    // WRED colour codes
    output logic [1:0] wred_red_o,
    output logic [1:0] wred_yellow_o,
    output logic [1:0] wred_green_o
);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] dscp_map_q;
    logic [7:0] mirror_snoop_q;
    logic [7:0] wred_q;
    logic [7:0] ptp_event_q;
    logic [7:0] ptp_general_q;

    // ****************************************
    // APB decode
    // ****************************************
    logic [SQG_IDX_W-1:0] idx;
    logic access;
    logic wr_lane;
    logic sel_dscp;
    logic sel_mirror;
    logic sel_wred;
    logic sel_ptp_evt;
    logic sel_ptp_gen;
    logic mapped;
    logic [7:0] rd_byte;

    always_comb begin
        idx = paddr_i[SQG_ADDR_W-1:2];
        access = psel_i && penable_i;
        wr_lane = access && pwrite_i && pstrb_i[0];
        sel_dscp = (idx == SQG_IDX_DSCP_LAST);
        sel_mirror = (idx == SQG_IDX_MIRROR_SNOOP);
        sel_wred = (idx == SQG_IDX_WRED);
        sel_ptp_evt = (idx == SQG_IDX_PTP_EVENT);
        sel_ptp_gen = (idx == SQG_IDX_PTP_GENERAL);
        mapped = sel_dscp || sel_mirror || sel_wred || sel_ptp_evt || sel_ptp_gen;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (sel_dscp) begin
            rd_byte = dscp_map_q;
        end else if (sel_mirror) begin
            rd_byte = mirror_snoop_q;
        end else if (sel_wred) begin
            rd_byte = wred_q;
        end else if (sel_ptp_evt) begin
            rd_byte = ptp_event_q;
        end else if (sel_ptp_gen) begin
            rd_byte = ptp_general_q;
        end
    end

    // Zero-wait slave: response flags follow the access phase directly
    always_comb begin
        pready_o = 1'b1;
        pslverr_o = access && !mapped;
    end

    // Read data captured at the end of setup, standing through the access cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i && mapped) begin
            prdata_o <= {24'h00_0000, rd_byte};
        end else begin
            prdata_o <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dscp_map_q <= SQG_RST_DSCP;
        end else if (wr_lane && sel_dscp) begin
            dscp_map_q <= pwdata_i[7:0] & SQG_MASK_DSCP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mirror_snoop_q <= SQG_RST_MIRROR;
        end else if (wr_lane && sel_mirror) begin
            mirror_snoop_q <= pwdata_i[7:0] & SQG_MASK_MIRROR;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wred_q <= SQG_RST_WRED;
        end else if (wr_lane && sel_wred) begin
            wred_q <= pwdata_i[7:0] & SQG_MASK_WRED;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptp_event_q <= SQG_RST_PTP;
        end else if (wr_lane && sel_ptp_evt) begin
            ptp_event_q <= pwdata_i[7:0] & SQG_MASK_PTP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ptp_general_q <= SQG_RST_PTP;
        end else if (wr_lane && sel_ptp_gen) begin
            ptp_general_q <= pwdata_i[7:0] & SQG_MASK_PTP;
        end
    end

    // ****************************************
    // Control fields
    // ****************************************
    logic ipv4_multicast_snoop_on;
    logic ipv6_listener_snoop_on;
    logic ipv6_listener_criteria_select;
    logic sniff_and_mode;
    logic evt_override;
    logic gen_override;
    logic [3:0] evt_prio;
    logic [3:0] gen_prio;
    logic [2:0] prio_63;
    logic [2:0] prio_62;

    always_comb begin
        ipv4_multicast_snoop_on = mirror_snoop_q[SQG_IGMP_ON_BIT];
        ipv6_listener_snoop_on = mirror_snoop_q[SQG_MLD_ON_BIT];
        ipv6_listener_criteria_select = mirror_snoop_q[SQG_MLD_SEL_BIT];
        sniff_and_mode = mirror_snoop_q[SQG_SNIFF_AND_BIT];
        evt_override = ptp_event_q[SQG_OVR_BIT];
        gen_override = ptp_general_q[SQG_OVR_BIT];
        evt_prio = ptp_event_q[SQG_PRIO_LSB +: 4];
        gen_prio = ptp_general_q[SQG_PRIO_LSB +: 4];
        prio_63 = dscp_map_q[SQG_DSCP63_LSB +: 3];
        prio_62 = dscp_map_q[SQG_DSCP62_LSB +: 3];
    end

    always_comb begin
        wred_red_o = wred_q[SQG_RED_LSB +: 2];
        wred_yellow_o = wred_q[SQG_YELLOW_LSB +: 2];
        wred_green_o = wred_q[SQG_GREEN_LSB +: 2];
    end

    // ****************************************
    // Frame classification
    // ****************************************
    logic mld_match;
    logic is_ip;
    logic [5:0] dscp;
    logic mld_pkt;

    sqg_mld_match u_mld (
        .criteria_sel_i(ipv6_listener_criteria_select),
        .next_hdr_i(frm_next_hdr_i),
        .hbh_next_hdr_i(frm_hbh_next_hdr_i),
        .match_o(mld_match)
    );

    always_comb begin
        is_ip = frm_ipv4_i || frm_ipv6_i;
        dscp = frm_tos_i[SQG_TOS_DSCP_LSB +: 6];
        mld_pkt = frm_ipv6_i && mld_match;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cls_valid_o <= 1'b0;
        end else begin
            cls_valid_o <= frm_valid_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dscp_hit_o <= 1'b0;
            dscp_prio_o <= 3'h0;
        end else begin
            dscp_hit_o <= 1'b0;
            dscp_prio_o <= 3'h0;
            if (frm_valid_i && is_ip && dscp == SQG_DSCP_63) begin
                dscp_hit_o <= 1'b1;
                dscp_prio_o <= prio_63;
            end else if (frm_valid_i && is_ip && dscp == SQG_DSCP_62) begin
                dscp_hit_o <= 1'b1;
                dscp_prio_o <= prio_62;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            host_fwd_o <= 1'b0;
            mld_pkt_o <= 1'b0;
        end else begin
            mld_pkt_o <= frm_valid_i && mld_pkt;
            host_fwd_o <= frm_valid_i
                && ((frm_ipv4_i && frm_igmp_i && ipv4_multicast_snoop_on)
                || (mld_pkt && ipv6_listener_snoop_on));
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mirror_o <= 1'b0;
        end else if (sniff_and_mode) begin
            mirror_o <= frm_valid_i && frm_src_sniff_i && frm_dst_sniff_i;
        end else begin
            mirror_o <= frm_valid_i && (frm_src_sniff_i || frm_dst_sniff_i);
        end
    end

    // Event override wins when a parser flags both message kinds
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            queue_prio_o <= 4'h0;
        end else if (frm_ptp_event_i && evt_override) begin
            queue_prio_o <= evt_prio;
        end else if (frm_ptp_general_i && !frm_ptp_event_i && gen_override) begin
            queue_prio_o <= gen_prio;
        end else begin
            queue_prio_o <= frm_qos_prio_i;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_ip_frame;
        frm_valid_i && (frm_ipv4_i || frm_ipv6_i);
    endsequence

    sequence s_wred_write;
        psel_i && penable_i && pwrite_i && pstrb_i[0] && sel_wred;
    endsequence

    sequence s_mld_frame;
        frm_valid_i && frm_ipv6_i && ipv6_listener_snoop_on;
    endsequence

    AST_DSCP63: assert property (
        s_ip_frame and (frm_tos_i[7:2] == 6'h3f)
        |=> dscp_hit_o && dscp_prio_o == $past(dscp_map_q[6:4]))
        else $error("DSCP 63 priority wrong");

    AST_DSCP62: assert property (
        s_ip_frame and (frm_tos_i[7:2] == 6'h3e)
        |=> dscp_hit_o && dscp_prio_o == $past(dscp_map_q[2:0]))
        else $error("DSCP 62 priority wrong");

    AST_DSCP_OTHER: assert property (
        frm_valid_i && frm_tos_i[7:3] != 5'h1f |=> !dscp_hit_o)
        else $error("DSCP hit for unmapped code");

    AST_IGMP_FWD: assert property (
        frm_valid_i && frm_ipv4_i && frm_igmp_i && mirror_snoop_q[6]
        |=> host_fwd_o)
        else $error("IGMP packet not sent to host");

    AST_SNOOP_OFF: assert property (
        frm_valid_i && !mirror_snoop_q[6] && !mirror_snoop_q[2] |=> !host_fwd_o)
        else $error("Host forward with snooping off");

    AST_MLD_EXT: assert property (
        s_mld_frame and (mirror_snoop_q[3] && frm_next_hdr_i == 8'd43)
        |=> host_fwd_o && mld_pkt_o)
        else $error("Extension-header MLD not forwarded");

    AST_MLD_HBH: assert property (
        s_mld_frame and (!mirror_snoop_q[3] && frm_next_hdr_i == 8'd0
        && frm_hbh_next_hdr_i == 8'd58)
        |=> host_fwd_o)
        else $error("Hop-by-hop MLD not forwarded");

    AST_MLD_REJECT: assert property (
        frm_valid_i && frm_ipv6_i && !mirror_snoop_q[3] && frm_next_hdr_i == 8'd43
        |=> !mld_pkt_o)
        else $error("Wrong MLD criteria applied");

    AST_MIRROR_AND: assert property (
        frm_valid_i && mirror_snoop_q[0] && (frm_src_sniff_i != frm_dst_sniff_i)
        |=> !mirror_o)
        else $error("AND mode mirrored a single match");

    AST_MIRROR_OR: assert property (
        frm_valid_i && !mirror_snoop_q[0] && frm_src_sniff_i |=> mirror_o)
        else $error("OR mode missed source match");

    AST_WRED_WRITE: assert property (
        s_wred_write ##1 1'b1
        |-> {wred_red_o, wred_yellow_o, wred_green_o} == $past(pwdata_i[5:0]))
        else $error("WRED codes not updated");

    AST_PTP_EVT: assert property (
        frm_ptp_event_i && ptp_event_q[7] |=> queue_prio_o == $past(ptp_event_q[3:0]))
        else $error("PTP event override ignored");

    AST_PTP_GEN: assert property (
        frm_ptp_general_i && !frm_ptp_event_i && ptp_general_q[7]
        |=> queue_prio_o == $past(ptp_general_q[3:0]))
        else $error("PTP non-event override ignored");

    AST_PTP_QOS: assert property (
        !frm_ptp_event_i && !frm_ptp_general_i |=> queue_prio_o == $past(frm_qos_prio_i))
        else $error("Normal QoS priority lost");

endmodule : sqg_controls

`default_nettype wire

// ==== sqg_pkg.sv ====
// Constants for the global classification and snooping control bank.
// Assumes an APB slave with 32-bit data; registers sit in the low byte.
//
// Summary of operation
// - DSCP 63 takes its priority from bits 6:4 of the last map register.
// - DSCP 62 takes its priority from bits 2:0; both fields reset to zero.
// - IPv4 snoop enable bit 6 sends every IGMP packet to the host port.
// - IPv6 listener snoop enable bit 2 sends every MLD packet to the host port.
// - Criteria select set: next header 43,44,50,51,60, or hop-by-hop with those.
// - Criteria select clear: next header 1 or 58, or hop-by-hop with those.
// - Mirror mode bit set mirrors only when source and destination both match.
// - Mirror mode bit clear mirrors when source or destination matches.
// - WRED colour codes: red 5:4 reset 3, yellow 3:2 reset 2, green 1:0 reset 1.
// - Event override bit 7 forces PTP event messages to priority bits 3:0.
// - Event override clear leaves PTP event messages at normal QoS priority.
// - Non-event override bit 7 forces PTP non-event messages to bits 3:0.
// - Non-event override clear leaves PTP non-event messages at normal QoS.

package sqg_pkg;

    // ****************************************
    // Bus and register indices
    // ****************************************
    localparam int unsigned SQG_ADDR_W = 12;
    localparam int unsigned SQG_IDX_W = 10;
    localparam logic [SQG_IDX_W-1:0] SQG_IDX_DSCP_LAST = 10'h35f;
    localparam logic [SQG_IDX_W-1:0] SQG_IDX_MIRROR_SNOOP = 10'h370;
    localparam logic [SQG_IDX_W-1:0] SQG_IDX_WRED = 10'h378;
    localparam logic [SQG_IDX_W-1:0] SQG_IDX_PTP_EVENT = 10'h37c;
    localparam logic [SQG_IDX_W-1:0] SQG_IDX_PTP_GENERAL = 10'h37d;

    // ****************************************
    // Reset values and writable bit masks
    // ****************************************
    localparam logic [7:0] SQG_RST_DSCP = 8'h00;
    localparam logic [7:0] SQG_RST_MIRROR = 8'h00;
    localparam logic [7:0] SQG_RST_WRED = 8'h39;
    localparam logic [7:0] SQG_RST_PTP = 8'h0f;
    localparam logic [7:0] SQG_MASK_DSCP = 8'h77;
    localparam logic [7:0] SQG_MASK_MIRROR = 8'h4d;
    localparam logic [7:0] SQG_MASK_WRED = 8'h3f;
    localparam logic [7:0] SQG_MASK_PTP = 8'h8f;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned SQG_DSCP63_LSB = 4;
    localparam int unsigned SQG_DSCP62_LSB = 0;
    localparam int unsigned SQG_IGMP_ON_BIT = 6;
    localparam int unsigned SQG_MLD_SEL_BIT = 3;
    localparam int unsigned SQG_MLD_ON_BIT = 2;
    localparam int unsigned SQG_SNIFF_AND_BIT = 0;
    localparam int unsigned SQG_RED_LSB = 4;
    localparam int unsigned SQG_YELLOW_LSB = 2;
    localparam int unsigned SQG_GREEN_LSB = 0;
    localparam int unsigned SQG_OVR_BIT = 7;
    localparam int unsigned SQG_PRIO_LSB = 0;
    localparam int unsigned SQG_TOS_DSCP_LSB = 2;

    // ****************************************
    // Code points
    // ****************************************
    localparam logic [5:0] SQG_DSCP_63 = 6'h3f;
    localparam logic [5:0] SQG_DSCP_62 = 6'h3e;
    localparam logic [7:0] SQG_NH_HOP_BY_HOP = 8'h00;
    localparam logic [7:0] SQG_NH_ICMP4 = 8'h01;
    localparam logic [7:0] SQG_NH_ICMP6 = 8'h3a;
    localparam logic [7:0] SQG_NH_ROUTING = 8'h2b;
    localparam logic [7:0] SQG_NH_FRAGMENT = 8'h2c;
    localparam logic [7:0] SQG_NH_ESP = 8'h32;
    localparam logic [7:0] SQG_NH_AUTH = 8'h33;
    localparam logic [7:0] SQG_NH_DEST_OPT = 8'h3c;

endpackage : sqg_pkg

// ==== sqg_mld_match.sv ====
// IPv6 listener-discovery packet detector.
// Assumes next-header fields are presented by the parser on clk_i.
`timescale 1ns/100ps
`default_nettype none

module sqg_mld_match
    import sqg_pkg::*;
(
    // Criteria and header fields
    input wire logic criteria_sel_i,
    input wire logic [7:0] next_hdr_i,
    input wire logic [7:0] hbh_next_hdr_i,
    // Result
    output logic match_o
);

    // ****************************************
    // Next-header code test
    // ****************************************
    function automatic logic nh_hit(input logic [7:0] nh, input logic sel);
        logic ext;
        logic icmp;
        ext = (nh == SQG_NH_ROUTING) || (nh == SQG_NH_FRAGMENT) || (nh == SQG_NH_ESP)
            || (nh == SQG_NH_AUTH) || (nh == SQG_NH_DEST_OPT);
        icmp = (nh == SQG_NH_ICMP4) || (nh == SQG_NH_ICMP6);
        nh_hit = sel ? ext : icmp;
    endfunction : nh_hit

    always_comb begin
        match_o = nh_hit(next_hdr_i, criteria_sel_i)
            || ((next_hdr_i == SQG_NH_HOP_BY_HOP)
            && nh_hit(hbh_next_hdr_i, criteria_sel_i));
    end

endmodule : sqg_mld_match

`default_nettype wire

// ==== sqg_controls_tb.sv ====
// Self-checking testbench for the global classification control bank.
// Assumes sqg_pkg and sqg_controls are compiled first; APB master and parser are the bench.
`timescale 1ns/100ps
`default_nettype none

module sqg_controls_tb;
    import sqg_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i, penable_i, pwrite_i;
    logic [SQG_ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0] pstrb_i;
    logic pready_o, pslverr_o;
    logic frm_valid_i, frm_ipv4_i, frm_ipv6_i, frm_igmp_i;
    logic [7:0] frm_tos_i, frm_next_hdr_i, frm_hbh_next_hdr_i;
    logic frm_src_sniff_i, frm_dst_sniff_i, frm_ptp_event_i, frm_ptp_general_i;
    logic [3:0] frm_qos_prio_i, queue_prio_o;
    logic cls_valid_o, dscp_hit_o, host_fwd_o, mld_pkt_o, mirror_o;
    logic [2:0] dscp_prio_o;
    logic [1:0] wred_red_o, wred_yellow_o, wred_green_o;
    int fails = 0;
    int checks = 0;
    logic [31:0] seed = 32'h0000_d58a;
    logic [7:0] sh [5];
    logic [SQG_ADDR_W-1:0] adr [5];
    logic [7:0] msk [5];

    always #4 clk_i = ~clk_i;

    sqg_controls DUT (
        .clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .frm_valid_i(frm_valid_i), .frm_ipv4_i(frm_ipv4_i),
        .frm_ipv6_i(frm_ipv6_i), .frm_tos_i(frm_tos_i), .frm_igmp_i(frm_igmp_i),
        .frm_next_hdr_i(frm_next_hdr_i), .frm_hbh_next_hdr_i(frm_hbh_next_hdr_i),
        .frm_src_sniff_i(frm_src_sniff_i), .frm_dst_sniff_i(frm_dst_sniff_i),
        .frm_ptp_event_i(frm_ptp_event_i), .frm_ptp_general_i(frm_ptp_general_i),
        .frm_qos_prio_i(frm_qos_prio_i), .cls_valid_o(cls_valid_o), .dscp_hit_o(dscp_hit_o),
        .dscp_prio_o(dscp_prio_o), .host_fwd_o(host_fwd_o), .mld_pkt_o(mld_pkt_o),
        .mirror_o(mirror_o), .queue_prio_o(queue_prio_o), .wred_red_o(wred_red_o),
        .wred_yellow_o(wred_yellow_o), .wred_green_o(wred_green_o)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction : lfsr

    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [SQG_ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= st;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        if (n == 20) begin
            fails++;
            end_sim();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    function automatic logic [7:0] pick_nh(input logic [3:0] k, input logic [7:0] rv);
        case (k[2:0])
            3'd0: pick_nh = 8'h00;
            3'd1: pick_nh = 8'h01;
            3'd2: pick_nh = 8'h3a;
            3'd3: pick_nh = 8'h2b;
            3'd4: pick_nh = 8'h2c;
            3'd5: pick_nh = 8'h32;
            3'd6: pick_nh = 8'h33;
            default: pick_nh = 8'h3c;
        endcase
        if (k[3]) pick_nh = rv;
    endfunction : pick_nh

    function automatic logic in_set(input logic [7:0] x, input logic sel);
        if (sel) return x == 8'd43 || x == 8'd44 || x == 8'd50 || x == 8'd51 || x == 8'd60;
        return x == 8'd1 || x == 8'd58;
    endfunction : in_set

    // Expected classification from the held descriptor and the shadow registers
    function automatic logic [10:0] expect_cls();
        logic [5:0] d;
        logic hit, mld, host, mir;
        logic [2:0] pr;
        logic [3:0] qp;
        d = frm_tos_i[7:2];
        hit = (frm_ipv4_i | frm_ipv6_i) && d >= 6'h3e;
        pr = !hit ? 3'h0 : (d[0] ? sh[0][6:4] : sh[0][2:0]);
        mld = frm_ipv6_i && (in_set(frm_next_hdr_i, sh[1][3]) ||
              (frm_next_hdr_i == 8'h00 && in_set(frm_hbh_next_hdr_i, sh[1][3])));
        host = (frm_ipv4_i && frm_igmp_i && sh[1][6]) || (mld && sh[1][2]);
        mir = sh[1][0] ? (frm_src_sniff_i & frm_dst_sniff_i) : (frm_src_sniff_i | frm_dst_sniff_i);
        qp = frm_qos_prio_i;
        if (frm_ptp_event_i && sh[3][7]) qp = sh[3][3:0];
        else if (!frm_ptp_event_i && frm_ptp_general_i && sh[4][7]) qp = sh[4][3:0];
        return {hit, pr, host, mld, mir, qp};
    endfunction : expect_cls

    task automatic frame();
        logic [31:0] r;
        logic [31:0] q;
        logic [10:0] e;
        seed = lfsr(seed);
        r = seed;
        seed = lfsr(seed);
        q = seed;
        @(posedge clk_i);
        frm_valid_i <= 1'b1;
        frm_ipv4_i <= r[1:0] == 2'd1;
        frm_ipv6_i <= r[1];
        frm_tos_i <= r[2] ? {5'b1_1111, r[3], r[5:4]} : r[11:4];
        frm_igmp_i <= r[1:0] == 2'd1 && r[12];
        frm_next_hdr_i <= pick_nh(q[3:0], q[15:8]);
        frm_hbh_next_hdr_i <= pick_nh(q[7:4], q[23:16]);
        frm_src_sniff_i <= r[19];
        frm_dst_sniff_i <= r[20];
        frm_ptp_event_i <= r[21];
        frm_ptp_general_i <= r[22];
        frm_qos_prio_i <= r[27:24];
        @(posedge clk_i);
        frm_valid_i <= 1'b0;
        #1;
        e = expect_cls();
        check(cls_valid_o, 1'b1);
        check({dscp_hit_o, dscp_prio_o}, e[10:7]);
        check({host_fwd_o, mld_pkt_o}, e[6:5]);
        check(mirror_o, e[4]);
        check(queue_prio_o, e[3:0]);
    endtask : frame

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] rd;
        logic err;
        logic [7:0] rst [5];
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        {frm_valid_i, frm_ipv4_i, frm_ipv6_i, frm_igmp_i, frm_tos_i} = '0;
        {frm_next_hdr_i, frm_hbh_next_hdr_i, frm_src_sniff_i, frm_dst_sniff_i} = '0;
        {frm_ptp_event_i, frm_ptp_general_i, frm_qos_prio_i} = '0;
        adr = '{{SQG_IDX_DSCP_LAST, 2'b00}, {SQG_IDX_MIRROR_SNOOP, 2'b00}, {SQG_IDX_WRED, 2'b00},
                {SQG_IDX_PTP_EVENT, 2'b00}, {SQG_IDX_PTP_GENERAL, 2'b00}};
        msk = '{8'h77, 8'h4d, 8'h3f, 8'h8f, 8'h8f};
        rst = '{8'h00, 8'h00, 8'h39, 8'h0f, 8'h0f};
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, adr[i], 32'h0, 4'h0, rd, err);
            check(rd, {24'h0, rst[i]});
            check(err, 1'b0);
            sh[i] = rst[i];
        end
        check({wred_red_o, wred_yellow_o, wred_green_o}, 6'h39);
        apb(1'b1, 12'hdc4, 32'hffff_ffff, 4'hf, rd, err);
        check(err, 1'b1);
        apb(1'b0, 12'hdc4, 32'h0, 4'h0, rd, err);
        check(err, 1'b1);
        check(rd, 32'h0);
        for (int p = 0; p < 16; p++) begin
            for (int i = 0; i < 5; i++) begin
                seed = lfsr(seed);
                apb(1'b1, adr[i], seed, 4'h1, rd, err);
                sh[i] = seed[7:0] & msk[i];
                apb(1'b1, adr[i], ~seed, 4'he, rd, err);
                apb(1'b0, adr[i], 32'h0, 4'h0, rd, err);
                check(rd, {24'h0, sh[i]});
            end
            check({wred_red_o, wred_yellow_o, wred_green_o}, sh[2][5:0]);
            repeat (30) frame();
        end
        end_sim();
    end

endmodule : sqg_controls_tb

`default_nettype wire
